//--- verilog/etcg_pkg.sv
// Constants and carrier types for the edge timed current gate.
// Assumes a single 100 MHz clock domain and an AXI4-Lite register master.
package etcg_pkg;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] ETCG_MEASURE_CONTROL_ADDR = 8'h00;
	localparam logic [7:0] ETCG_CURRENT_SOURCE_CONTROL_ADDR = 8'h04;
	localparam logic [7:0] ETCG_IRQ_STATUS_ADDR = 8'h08;
	localparam logic [7:0] ETCG_IRQ_ENABLE_ADDR = 8'h0c;
	localparam logic [7:0] ETCG_IRQ_CLEAR_ADDR = 8'h10;
	// ------------------------------------------------------------
	// Measure control field positions
	// ------------------------------------------------------------
	localparam int ETCG_UNIT_ON_BIT = 15;
	localparam int ETCG_IDLE_HALT_BIT = 13;
	localparam int ETCG_DELAY_GEN_BIT = 12;
	localparam int ETCG_EDGE_ACCEPT_BIT = 11;
	localparam int ETCG_EDGE_ORDER_BIT = 10;
	localparam int ETCG_DISCHARGE_BIT = 9;
	localparam int ETCG_TRIG_OUT_BIT = 8;
	localparam int ETCG_SECOND_POL_BIT = 7;
	localparam int ETCG_SECOND_SRC_LSB = 5;
	localparam int ETCG_FIRST_POL_BIT = 4;
	localparam int ETCG_FIRST_SRC_LSB = 2;
	localparam int ETCG_SECOND_SEEN_BIT = 1;
	localparam int ETCG_FIRST_SEEN_BIT = 0;
	localparam logic [15:0] ETCG_MEASURE_CONTROL_RESET = 16'h0000;
	localparam logic [15:0] ETCG_MEASURE_CONTROL_WMASK = 16'hbfff;
	// ------------------------------------------------------------
	// Current source control field positions
	// ------------------------------------------------------------
	localparam int ETCG_TRIM_LSB = 10;
	localparam int ETCG_RANGE_LSB = 8;
	localparam logic [15:0] ETCG_CURRENT_SOURCE_CONTROL_RESET = 16'h0000;
	localparam logic [15:0] ETCG_CURRENT_SOURCE_CONTROL_WMASK = 16'hff00;
	// ------------------------------------------------------------
	// Source selector codes and interrupt bits
	// ------------------------------------------------------------
	localparam logic [1:0] ETCG_SRC_TIMER = 2'h0;
	localparam logic [1:0] ETCG_SRC_COMPARE = 2'h1;
	localparam logic [1:0] ETCG_SRC_PIN_TWO = 2'h2;
	localparam logic [1:0] ETCG_SRC_PIN_ONE = 2'h3;
	localparam int ETCG_IRQ_FIRST = 0;
	localparam int ETCG_IRQ_SECOND = 1;
	localparam int ETCG_IRQ_TRIP = 2;
	localparam logic [1:0] ETCG_RESP_OKAY = 2'h0;
	localparam logic [1:0] ETCG_RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [5:0] trim;
		logic [1:0] range;
		logic source_on;
		logic ground;
	} etcg_source_t;
endpackage : etcg_pkg

//--- verilog/etcg_gate.sv
// Edge timed current gate: edge capture, source gating, delay pulse, AXI4-Lite registers.
// Assumes edge sources and the comparator output arrive asynchronously to clk_in.
`timescale 1ns/1ps
`default_nettype none
module etcg_gate import etcg_pkg::*; (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic cpu_idle_in,
	input wire logic timer_event_in,
	input wire logic compare_event_in,
	input wire logic ext_edge_pin_one_in,
	input wire logic ext_edge_pin_two_in,
	input wire logic comparator_trip_in,
	output etcg_source_t source_out,
	output logic comparator_b_input_sel_out,
	output logic delay_pulse_out,
	output logic measure_pulse_out,
	output logic trigger_out,
	output logic irq_out,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	localparam int NSYNC = 5;
	logic [NSYNC-1:0] raw;
	logic [NSYNC-1:0] s1_q, s2_q, s3_q, lvl_q;
	logic [NSYNC-1:0] rise, fall;
	assign raw = {comparator_trip_in, ext_edge_pin_two_in, ext_edge_pin_one_in,
		compare_event_in, timer_event_in};
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge clk_in) begin
				if (reset_in) begin
					s1_q[gi] <= 1'b0;
					s2_q[gi] <= 1'b0;
					s3_q[gi] <= 1'b0;
					lvl_q[gi] <= 1'b0;
				end else begin
					s1_q[gi] <= raw[gi];
					s2_q[gi] <= s1_q[gi];
					s3_q[gi] <= s2_q[gi];
					if (s2_q[gi] == s3_q[gi])
						lvl_q[gi] <= s3_q[gi];
				end
			end
			assign rise[gi] = (s2_q[gi] == s3_q[gi]) && s3_q[gi] && !lvl_q[gi];
			assign fall[gi] = (s2_q[gi] == s3_q[gi]) && !s3_q[gi] && lvl_q[gi];
		end
	endgenerate

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [15:0] ctl_q, cur_q;
	logic [2:0] irq_stat_q, irq_en_q;
	logic unit_run;
	logic [1:0] edge_hit;
	logic trip_event;
	assign unit_run = ctl_q[ETCG_UNIT_ON_BIT] &&
		!(ctl_q[ETCG_IDLE_HALT_BIT] && cpu_idle_in);

	// Edge qualification per channel: source select then polarity
	logic [1:0] sel [2];
	logic [1:0] pol;
	assign sel[0] = ctl_q[ETCG_FIRST_SRC_LSB +: 2];
	assign sel[1] = ctl_q[ETCG_SECOND_SRC_LSB +: 2];
	assign pol = {ctl_q[ETCG_SECOND_POL_BIT], ctl_q[ETCG_FIRST_POL_BIT]};
	generate
		for (gi = 0; gi < 2; gi++) begin : g_chan
			logic r, f;
			always_comb begin
				unique case (sel[gi])
					ETCG_SRC_PIN_ONE: begin r = rise[2]; f = fall[2]; end
					ETCG_SRC_PIN_TWO: begin r = rise[3]; f = fall[3]; end
					ETCG_SRC_COMPARE: begin r = rise[1]; f = fall[1]; end
					ETCG_SRC_TIMER: begin r = rise[0]; f = fall[0]; end
				endcase
			end
			assign edge_hit[gi] = unit_run && ctl_q[ETCG_EDGE_ACCEPT_BIT] &&
				(pol[gi] ? r : f);
		end
	endgenerate

	logic first_seen, second_seen, second_ok;
	assign first_seen = ctl_q[ETCG_FIRST_SEEN_BIT];
	assign second_seen = ctl_q[ETCG_SECOND_SEEN_BIT];
	assign second_ok = edge_hit[1] &&
		(!ctl_q[ETCG_EDGE_ORDER_BIT] || first_seen);
	assign trip_event = unit_run && ctl_q[ETCG_DELAY_GEN_BIT] && rise[4];

	// ------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------
	logic aw_held_q, w_held_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic do_write;
	logic [15:0] wmask;
	logic [15:0] wval;
	assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
	assign s_axi_wready = !w_held_q && !s_axi_bvalid;
	assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wmask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	assign wval = wdata_q[15:0];

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= ETCG_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				unique case (awaddr_q)
					ETCG_MEASURE_CONTROL_ADDR, ETCG_CURRENT_SOURCE_CONTROL_ADDR,
					ETCG_IRQ_ENABLE_ADDR, ETCG_IRQ_CLEAR_ADDR:
						s_axi_bresp <= ETCG_RESP_OKAY;
					default: s_axi_bresp <= ETCG_RESP_SLVERR;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Control register; seen bits set by hardware win over a software clear
	logic wr_ctl;
	assign wr_ctl = do_write && awaddr_q == ETCG_MEASURE_CONTROL_ADDR;
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			ctl_q <= ETCG_MEASURE_CONTROL_RESET;
		end else begin
			if (wr_ctl)
				ctl_q <= (ctl_q & ~(wmask & ETCG_MEASURE_CONTROL_WMASK)) |
					(wval & wmask & ETCG_MEASURE_CONTROL_WMASK);
			if (edge_hit[0])
				ctl_q[ETCG_FIRST_SEEN_BIT] <= 1'b1;
			if (second_ok)
				ctl_q[ETCG_SECOND_SEEN_BIT] <= 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in)
			cur_q <= ETCG_CURRENT_SOURCE_CONTROL_RESET;
		else if (do_write && awaddr_q == ETCG_CURRENT_SOURCE_CONTROL_ADDR)
			cur_q <= (cur_q & ~(wmask & ETCG_CURRENT_SOURCE_CONTROL_WMASK)) |
				(wval & wmask & ETCG_CURRENT_SOURCE_CONTROL_WMASK);
	end

	// ------------------------------------------------------------
	// Interrupts
	// ------------------------------------------------------------
	logic [2:0] irq_set;
	logic [2:0] irq_clr;
	assign irq_set = {trip_event, second_ok, edge_hit[0]};
	assign irq_clr = (do_write && awaddr_q == ETCG_IRQ_CLEAR_ADDR && wstrb_q[0]) ?
		wdata_q[2:0] : 3'h0;
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			irq_stat_q <= 3'h0;
			irq_en_q <= 3'h0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
			if (do_write && awaddr_q == ETCG_IRQ_ENABLE_ADDR && wstrb_q[0])
				irq_en_q <= wdata_q[2:0];
		end
	end
	assign irq_out = |(irq_stat_q & irq_en_q);

	// Read channel
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= ETCG_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= ETCG_RESP_OKAY;
			unique case (s_axi_araddr)
				ETCG_MEASURE_CONTROL_ADDR: s_axi_rdata <= {16'h0000, ctl_q};
				ETCG_CURRENT_SOURCE_CONTROL_ADDR: s_axi_rdata <= {16'h0000, cur_q};
				ETCG_IRQ_STATUS_ADDR: s_axi_rdata <= {29'h0, irq_stat_q};
				ETCG_IRQ_ENABLE_ADDR: s_axi_rdata <= {29'h0, irq_en_q};
				ETCG_IRQ_CLEAR_ADDR: s_axi_rdata <= 32'h0000_0000;
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= ETCG_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Analog control outputs
	// ------------------------------------------------------------
	logic charging;
	logic pulse_q;
	assign charging = unit_run && first_seen && !second_seen;
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			source_out <= '0;
			comparator_b_input_sel_out <= 1'b0;
			measure_pulse_out <= 1'b0;
			trigger_out <= 1'b0;
		end else begin
			source_out.trim <= cur_q[ETCG_TRIM_LSB +: 6];
			source_out.range <= cur_q[ETCG_RANGE_LSB +: 2];
			source_out.source_on <= charging && !ctl_q[ETCG_DISCHARGE_BIT];
			source_out.ground <= ctl_q[ETCG_DISCHARGE_BIT];
			comparator_b_input_sel_out <= unit_run && ctl_q[ETCG_DELAY_GEN_BIT];
			measure_pulse_out <= charging && !ctl_q[ETCG_DELAY_GEN_BIT];
			trigger_out <= ctl_q[ETCG_TRIG_OUT_BIT] && second_ok;
		end
	end

	// Delay pulse: set on trip, cleared when software clears the first seen bit or the delay gen bit
	always_ff @(posedge clk_in) begin
		if (reset_in)
			pulse_q <= 1'b0;
		else if (trip_event && first_seen)
			pulse_q <= 1'b1;
		else if (!first_seen || !ctl_q[ETCG_DELAY_GEN_BIT])
			pulse_q <= 1'b0;
	end
	assign delay_pulse_out = pulse_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_order;
		@(posedge clk_in) disable iff (reset_in)
		(ctl_q[ETCG_EDGE_ORDER_BIT] && !first_seen && !wr_ctl && !edge_hit[0])
			|=> !$rose(ctl_q[ETCG_SECOND_SEEN_BIT]);
	endproperty
	a_order: assert property (p_order) else $error("second edge before first");
	property p_block;
		@(posedge clk_in) disable iff (reset_in)
		!ctl_q[ETCG_EDGE_ACCEPT_BIT] && !wr_ctl |=>
			$stable(ctl_q[ETCG_SECOND_SEEN_BIT:ETCG_FIRST_SEEN_BIT]);
	endproperty
	a_block: assert property (p_block) else $error("edge accepted while blocked");
	property p_off;
		@(posedge clk_in) disable iff (reset_in)
		!ctl_q[ETCG_UNIT_ON_BIT] |=> !source_out.source_on && !measure_pulse_out;
	endproperty
	a_off: assert property (p_off) else $error("unit active while off");
	property p_idle;
		@(posedge clk_in) disable iff (reset_in)
		ctl_q[ETCG_IDLE_HALT_BIT] && cpu_idle_in && !wr_ctl |=>
			$stable(ctl_q[ETCG_SECOND_SEEN_BIT:ETCG_FIRST_SEEN_BIT]);
	endproperty
	a_idle: assert property (p_idle) else $error("unit ran in idle");
	property p_sticky;
		@(posedge clk_in) disable iff (reset_in)
		first_seen && !wr_ctl |=> first_seen;
	endproperty
	a_sticky: assert property (p_sticky) else $error("seen bit lost");
	property p_charge;
		@(posedge clk_in) disable iff (reset_in)
		source_out.source_on |-> $past(first_seen) && !$past(second_seen);
	endproperty
	a_charge: assert property (p_charge) else $error("current outside interval");
	property p_ground;
		@(posedge clk_in) disable iff (reset_in)
		ctl_q[ETCG_DISCHARGE_BIT] |=> source_out.ground && !source_out.source_on;
	endproperty
	a_ground: assert property (p_ground) else $error("discharge not grounded");
	property p_trip;
		@(posedge clk_in) disable iff (reset_in)
		trip_event && first_seen |=> delay_pulse_out;
	endproperty
	a_trip: assert property (p_trip) else $error("no pulse after trip");
	property p_irq;
		@(posedge clk_in) disable iff (reset_in)
		edge_hit[0] |=> irq_stat_q[ETCG_IRQ_FIRST];
	endproperty
	a_irq: assert property (p_irq) else $error("first edge status missing");
endmodule : etcg_gate
`default_nettype wire

//--- testbench/etcg_analog_model.sv
// Behavioural far side of the gate: four edge sources and the delay comparator.
// Assumes the bench sets edge levels on clk_in edges and one clock drives all.
`timescale 1ns/1ps
`default_nettype none
module etcg_analog_model import etcg_pkg::*; #(
	parameter int CHARGE_CYCLES = 20
) (
	input wire logic clk_in,
	input wire logic [3:0] edge_lvl_in,
	input wire etcg_source_t source_in,
	input wire logic b_sel_in,
	output logic timer_event_out,
	output logic compare_event_out,
	output logic pin_two_out,
	output logic pin_one_out,
	output logic trip_out
);
	int charge_q = 0;
	// ------------------------------------------------------------
	// Edge sources, indexed by their selector code
	// ------------------------------------------------------------
	// Pins and pulse output are taken as already mapped
	assign timer_event_out = edge_lvl_in[0];
	assign compare_event_out = edge_lvl_in[1];
	assign pin_two_out = edge_lvl_in[2];
	assign pin_one_out = edge_lvl_in[3];
	// ------------------------------------------------------------
	// Delay capacitor
	// ------------------------------------------------------------
	// Charges only while sourced into input b; grounding empties it
	always_ff @(posedge clk_in) begin
		if (source_in.ground)
			charge_q <= 0;
		else if (source_in.source_on && b_sel_in && charge_q < CHARGE_CYCLES)
			charge_q <= charge_q + 1;
	end
	assign trip_out = (charge_q >= CHARGE_CYCLES);
endmodule // etcg_analog_model
`default_nettype wire

//--- testbench/etcg_gate_tb.sv
// Self-checking bench for the edge timed current gate.
// Assumes the analog model on the far side and an AXI4-Lite master built here.
`timescale 1ns/1ps
`default_nettype none
module etcg_gate_tb import etcg_pkg::*;;
	logic clk_in = 0;
	logic reset_in = 1;
	logic cpu_idle = 0;
	logic [3:0] lvl = 4'h0;
	logic tmr, cmp, p1, p2, trip, bsel, dly, meas, trig, irq;
	etcg_source_t src;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	int err_count = 0;
	int checked = 0;
	int cycles = 0;
	int trig_cnt = 0;

	etcg_gate dut (.clk_in(clk_in), .reset_in(reset_in), .cpu_idle_in(cpu_idle),
		.timer_event_in(tmr), .compare_event_in(cmp), .ext_edge_pin_one_in(p1),
		.ext_edge_pin_two_in(p2), .comparator_trip_in(trip), .source_out(src),
		.comparator_b_input_sel_out(bsel), .delay_pulse_out(dly), .measure_pulse_out(meas),
		.trigger_out(trig), .irq_out(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	etcg_analog_model model (.clk_in(clk_in), .edge_lvl_in(lvl), .source_in(src),
		.b_sel_in(bsel), .timer_event_out(tmr), .compare_event_out(cmp),
		.pin_two_out(p2), .pin_one_out(p1), .trip_out(trip));

	// ------------------------------------------------------------
	// Clock, watchdog and trigger pulse count
	// ------------------------------------------------------------
	initial begin
		forever #5 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (trig === 1'b1)
			trig_cnt <= trig_cnt + 1;
		if (cycles == 20000) begin
			err_count++;
			finish_test();
		end
	end

	// ------------------------------------------------------------
	// Compare, bus and pin tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", what, exp, got);
			err_count++;
		end
	endtask
	task automatic chkb(input string what, input logic exp, input logic got);
		chk(what, {31'h0, exp}, {31'h0, got});
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic done;
		done = 0;
		@(posedge clk_in);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done) begin
			@(posedge clk_in);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid) begin
				done = 1;
				bready <= 1'b0;
				chk("write response", {30'h0, ETCG_RESP_OKAY}, {30'h0, bresp});
			end
		end
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic done;
		done = 0;
		@(posedge clk_in);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done) begin
			@(posedge clk_in);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid) begin
				done = 1;
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				chkb("read address refused while answering", 1'b0, arready);
			end
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk("register read", exp, d);
		chk("read response", {30'h0, ETCG_RESP_OKAY}, {30'h0, r});
	endtask
	task automatic pin(input int i, input logic v);
		@(posedge clk_in);
		lvl[i] <= v;
		repeat (8) @(posedge clk_in);
		@(negedge clk_in);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_regs();
		logic [31:0] d;
		logic [1:0] r;
		rchk(8'h00, 32'h0);
		rchk(8'h04, 32'h0);
		rchk(8'h08, 32'h0);
		rchk(8'h0c, 32'h0);
		rd(8'h14, d, r);
		chk("unmapped data", 32'h0, d);
		chk("unmapped response", {30'h0, ETCG_RESP_SLVERR}, {30'h0, r});
		wr(8'h04, 32'hffffffff);
		rchk(8'h04, 32'hff00);
		wr(8'h04, 32'h7f00);
		rchk(8'h04, 32'h7f00);
		chk("trim", 32'h1f, {26'h0, src.trim});
		chk("range", 32'h3, {30'h0, src.range});
		wr(8'h04, 32'h8500);
		rchk(8'h04, 32'h8500);
		chk("trim", 32'h21, {26'h0, src.trim});
		chk("range", 32'h1, {30'h0, src.range});
		wr(8'h00, 32'h4000);
		rchk(8'h00, 32'h0);
		$display("test registers done");
	endtask
	task automatic t_sources();
		logic [31:0] c;
		for (int s = 0; s < 4; s++) begin
			c = 32'h8d10 | (32'(s) << 5) | (32'(s) << 2);
			wr(8'h00, c);
			pin(s, 1'b1);
			chkb("measure pulse", 1'b1, meas);
			chkb("source on", 1'b1, src.source_on);
			rchk(8'h00, c | 32'h1);
			pin(s, 1'b0);
			chkb("measure pulse", 1'b0, meas);
			chkb("source on", 1'b0, src.source_on);
			rchk(8'h00, c | 32'h3);
		end
		chk("trigger pulses", 32'h4, trig_cnt);
		$display("test sources done");
	endtask
	task automatic t_order();
		wr(8'h00, 32'h8cdc);
		pin(2, 1'b1);
		rchk(8'h00, 32'h8cdc);
		pin(2, 1'b0);
		wr(8'h00, 32'h8edc);
		pin(3, 1'b1);
		chkb("ground", 1'b1, src.ground);
		chkb("source on", 1'b0, src.source_on);
		rchk(8'h00, 32'h8edd);
		wr(8'h00, 32'h88dc);
		rchk(8'h00, 32'h88dc);
		pin(2, 1'b1);
		rchk(8'h00, 32'h88de);
		chk("trigger pulses", 32'h4, trig_cnt);
		pin(2, 1'b0);
		pin(3, 1'b0);
		wr(8'h00, 32'h80dc);
		pin(3, 1'b1);
		rchk(8'h00, 32'h80dc);
		pin(3, 1'b0);
		wr(8'h00, 32'h08dc);
		pin(3, 1'b1);
		rchk(8'h00, 32'h08dc);
		pin(3, 1'b0);
		@(posedge clk_in);
		cpu_idle <= 1'b1;
		wr(8'h00, 32'ha8dc);
		pin(3, 1'b1);
		rchk(8'h00, 32'ha8dc);
		pin(3, 1'b0);
		@(posedge clk_in);
		cpu_idle <= 1'b0;
		pin(3, 1'b1);
		rchk(8'h00, 32'ha8dd);
		pin(3, 1'b0);
		wr(8'h00, 32'h880c);
		pin(3, 1'b1);
		rchk(8'h00, 32'h880c);
		pin(3, 1'b0);
		rchk(8'h00, 32'h880d);
		$display("test ordering and gating done");
	endtask
	task automatic t_delay();
		logic [31:0] d;
		logic [1:0] r;
		int n;
		wr(8'h10, 32'h7);
		wr(8'h0c, 32'h0);
		wr(8'h00, 32'h981c);
		pin(3, 1'b1);
		chkb("comparator b route", 1'b1, bsel);
		chkb("source on", 1'b1, src.source_on);
		chkb("delay pulse early", 1'b0, dly);
		n = 0;
		while (dly !== 1'b1 && n < 200) begin
			@(negedge clk_in);
			n++;
		end
		chkb("delay pulse", 1'b1, dly);
		chkb("irq masked", 1'b0, irq);
		rd(8'h08, d, r);
		chk("trip status", 32'h4, d & 32'h4);
		wr(8'h0c, 32'h4);
		rchk(8'h0c, 32'h4);
		chkb("irq raised", 1'b1, irq);
		wr(8'h10, 32'h4);
		rchk(8'h10, 32'h0);
		chkb("irq cleared", 1'b0, irq);
		$display("test delay mode done");
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge clk_in);
		reset_in <= 1'b0;
		t_regs();
		t_sources();
		t_order();
		t_delay();
		finish_test();
	end
endmodule // etcg_gate_tb
`default_nettype wire
